/* File: dv/testbench.sv */
// Self-checking bench for the register map decoder, with random data from a fixed seed.
// Assumes the host model drives the bus and the bench drives the engine-side inputs.
`timescale 1ns/1ps

module testbench;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary value.
    localparam logic [7:0] ID  = 8'hc3; // Arbitrary value.
    logic        clk = 1'b0, rst = 1'b1, cs_n, rd_n, wr_n, oe, pop, tld, fwr, int_pend, int_out;
    logic        tx_serial, rx_pin, rx_serial, b;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, rx_char, tx_data, fifo_ctl, line_stat, lc, ie, ef, mc, q, v, last_tx;
    logic [7:0]  ch [4];
    logic [7:0]  rc1, rc2, pc1, pc2;
    logic [5:0]  int_src;
    logic [1:0]  fifo_on;
    logic [3:0]  modem_in, mold;
    logic [15:0] divisor;
    integer      seed = 57393, fails = 0, n_compared = 0, npop = 0, cyc = 0, nfwr = 0, noe = 0, nrd = 0;

    always #2 clk = ~clk;

    urmd_host u_host (.clk(clk), .cs_n(cs_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata));

    urmd_top #(.rev_code(REV), .id_code(ID)) DUT (
        .clk(clk), .rst(rst), .cs_n(cs_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata),
        .rdata(rdata), .rdata_oe(oe), .rx_char(rx_char), .rx_pop(pop), .tx_data(tx_data), .tx_load(tld),
        .fifo_ctl(fifo_ctl), .fifo_ctl_wr(fwr), .line_stat(line_stat), .int_src(int_src), .fifo_on(fifo_on),
        .int_pend(int_pend), .int_out(int_out), .modem_in(modem_in), .divisor(divisor), .line_ctl(lc),
        .int_en(ie), .enh_fn(ef), .modem_ctl(mc), .resume_char_1(rc1), .resume_char_2(rc2),
        .pause_char_1(pc1), .pause_char_2(pc2), .tx_serial(tx_serial), .rx_pin(rx_pin), .rx_serial(rx_serial));

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host.acc(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] exp);
        u_host.acc(1'b0, a, 8'h00, q);
        nrd++;
        chk(nm, exp, q);
    endtask : rdc

    // Extended bits survive only while the enhanced enable is set.
    function automatic logic [7:0] mask(input logic [7:0] d, input logic [7:0] m, input logic e);
        return e ? d : (d & m);
    endfunction : mask

    // Pulses last one cycle, so they are caught at every edge; the cycle count cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        if (tld === 1'b1) last_tx = tx_data;
        if (pop === 1'b1) npop++;
        if (fwr === 1'b1) nfwr++;
        if (oe === 1'b1) noe++;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        {rx_char, line_stat, int_src, fifo_on, int_pend, modem_in, tx_serial, rx_pin} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("line_ctl", 3'h3, 8'h00);
        rdc("int_en", 3'h1, 8'h00);
        rdc("modem_ctl", 3'h4, 8'h00);
        $display("test reset done");
        repeat (6)
        begin
            v = $random(seed);
            wr(3'h7, v);
            rdc("scratchpad", 3'h7, v);
            wr(3'h3, v & 8'h7f);
            rdc("line_ctl", 3'h3, v & 8'h7f);
            chk("line_ctl out", v & 8'h7f, lc);
            wr(3'h0, v);
            chk("tx_data", v, last_tx);
            v = $random(seed);
            @(posedge clk) rx_char <= v;
            rdc("rx_holding", 3'h0, v);
        end
        chk("rx_pop", 8'h06, npop[7:0]);
        $display("test data done");
        wr(3'h3, 8'h80);
        rdc("revision_code", 3'h0, REV);
        rdc("device_id_code", 3'h1, ID);
        v = $random(seed) | 1;
        wr(3'h0, v);
        rdc("divisor_low", 3'h0, v);
        chk("divisor low", v, divisor[7:0]);
        rdc("divisor_high", 3'h1, 8'h00);
        wr(3'h1, ~v);
        chk("divisor", ~v, divisor[15:8]);
        $display("test divisor done");
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        rdc("enhanced_function", 3'h2, 8'h10);
        chk("enh_fn", 8'h10, ef);
        for (int i = 0; i < 4; i++)
        begin
            ch[i] = $random(seed);
            wr(3'(4 + i), ch[i]);
        end
        chk("resume_char_1", ch[0], rc1);
        chk("resume_char_2", ch[1], rc2);
        chk("pause_char_1", ch[2], pc1);
        chk("pause_char_2", ch[3], pc2);
        for (int e = 1; e >= 0; e--)
        begin
            wr(3'h3, 8'hbf);
            wr(3'h2, e ? 8'h10 : 8'h00);
            wr(3'h3, 8'h03);
            v = $random(seed);
            {fifo_on, int_src} <= $random(seed);
            wr(3'h1, v);
            rdc("int_en", 3'h1, mask(v, 8'h0f, e[0]));
            chk("int_en out", mask(v, 8'h0f, e[0]), ie);
            wr(3'h4, v & 8'hb7);
            rdc("modem_ctl", 3'h4, mask(v & 8'hb7, 8'h1b, e[0]));
            chk("modem_ctl out", mask(v & 8'hb7, 8'h1b, e[0]), mc);
            wr(3'h2, v);
            chk("fifo_ctl", mask(v, 8'hcf, e[0]), fifo_ctl);
            rdc("interrupt_status", 3'h2, mask({fifo_on, int_src}, 8'hcf, e[0]));
        end
        chk("fifo_ctl_wr", 8'h02, nfwr[7:0]);
        $display("test enhanced done");
        line_stat <= $random(seed);
        wr(3'h7, 8'ha5);
        wr(3'h5, 8'h5a);
        wr(3'h6, 8'hff);
        rdc("line_status", 3'h5, line_stat);
        rdc("scratchpad", 3'h7, 8'ha5);
        rdc("line_ctl", 3'h3, 8'h03);
        repeat (4)
        begin
            mold = modem_in;
            v = $random(seed);
            @(posedge clk) modem_in <= v[3:0];
            repeat (2) @(posedge clk);
            rdc("modem_status", 3'h6, {v[3:0], v[3:0] ^ mold});
            rdc("modem_status", 3'h6, {v[3:0], 4'h0});
        end
        $display("test status done");
        for (int m = 0; m < 4; m++)
        begin
            wr(3'h4, {3'h0, m[1], m[0], 3'h0});
            repeat (4)
            begin
                b = $random(seed);
                @(posedge clk);
                tx_serial <= b;
                rx_pin    <= !b;
                int_pend  <= !b;
                repeat (2) @(posedge clk);
                chk("rx_serial", {7'h0, m[1] ? b : !b}, {7'h0, rx_serial});
                chk("int_out", {7'h0, m[0] & !b}, {7'h0, int_out});
            end
        end
        chk("rdata_oe", 8'(2 * nrd), noe[7:0]);
        $display("test outputs done");
        stop_test();
    end
endmodule : testbench

/* File: dv/urmd_host.sv */
// Host processor model that reaches the register map over the parallel register bus.
// Assumes the bench calls acc one access at a time; there is no ready signal on this bus.
`timescale 1ns/1ps

module urmd_host (
    input  wire logic       clk,
    output logic            cs_n,
    output logic      [2:0] addr,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial
    begin
        {cs_n, rd_n, wr_n} = 3'h7;
        addr  = 3'h0;
        wdata = 8'h00;
    end

    // The strobe is held for two edges and released for one, so every access is taken once.
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cs_n  <= 1'b0;
        addr  <= a;
        wdata <= d;
        rd_n  <= w;
        wr_n  <= !w;
        repeat (2) @(posedge clk);
        {cs_n, rd_n, wr_n} <= 3'h7;
        addr  <= ~a;
        wdata <= ~d;
        @(posedge clk);
        q = rdata;
    endtask : acc
endmodule : urmd_host

/* File: src/urmd_pkg.sv */
// Types shared by the register map decoder.
// Assumes nothing of its surroundings.
package urmd_pkg;

    typedef enum logic [1:0] {
        URMD_NORMAL,
        URMD_DIVISOR,
        URMD_ENHANCED
    } urmd_bank_e;

    typedef struct packed {
        logic [7:0] line_control;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        logic [7:0] interrupt_enable;
        logic [7:0] enhanced_function;
        logic [7:0] modem_control;
        logic [7:0] scratchpad;
        logic [7:0] xon1;
        logic [7:0] xon2;
        logic [7:0] xoff1;
        logic [7:0] xoff2;
        logic [7:0] rdat;
        logic       oe;
        logic       rd_q;
        logic       wr_q;
        logic [3:0] mprev;
        logic [3:0] delta;
        logic [7:0] txd;
        logic       txl;
        logic       pop;
        logic [7:0] fifo_control;
        logic       fcr_wr;
        logic       irq;
        logic       rxs;
    } urmd_state_s;

endpackage : urmd_pkg

/* File: src/urmd_regs.svh */
// Register offsets, field positions and reset values of the register map decoder.
// Included by the top module; holds defines only.
`ifndef URMD_REGS_SVH
`define URMD_REGS_SVH

`define URMD_OFF_DATA   3'h0
`define URMD_OFF_IEN    3'h1
`define URMD_OFF_ISTAT  3'h2
`define URMD_OFF_LCTL   3'h3
`define URMD_OFF_MCTL   3'h4
`define URMD_OFF_LSTAT  3'h5
`define URMD_OFF_MSTAT  3'h6
`define URMD_OFF_SCR    3'h7

`define URMD_LCR_DLAB   7
`define URMD_EFR_ENH    4
`define URMD_MCR_INTEN  3
`define URMD_MCR_LOOP   4
`define URMD_LCR_MAGIC  8'hbf

`define URMD_IER_EXT    8'hf0
`define URMD_ISR_EXT    8'h30
`define URMD_FCR_EXT    8'h30
`define URMD_MCR_EXT    8'he4

`define URMD_RST_BYTE   8'h00
`define URMD_RST_NIB    4'h0
`define URMD_ZERO_DIV   16'h0000

`endif

/* File: src/urmd_top.sv */
// Host register file and address decoder of a single channel serial controller.
// Assumes all inputs synchronous to clk; the serial engine sits outside.
`timescale 1ns/1ps
`include "urmd_regs.svh"

module urmd_top #(
    parameter logic [7:0] rev_code = 8'h01, // Arbitrary value.
    parameter logic [7:0] id_code  = 8'h5a  // Arbitrary value.
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic [2:0] addr,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    output logic            rdata_oe,
    input  wire logic [7:0] rx_char,
    output logic            rx_pop,
    output logic      [7:0] tx_data,
    output logic            tx_load,
    output logic      [7:0] fifo_ctl,
    output logic            fifo_ctl_wr,
    input  wire logic [7:0] line_stat,
    input  wire logic [5:0] int_src,
    input  wire logic [1:0] fifo_on,
    input  wire logic       int_pend,
    output logic            int_out,
    input  wire logic [3:0] modem_in,
    output logic      [15:0] divisor,
    output logic      [7:0] line_ctl,
    output logic      [7:0] int_en,
    output logic      [7:0] enh_fn,
    output logic      [7:0] modem_ctl,
    output logic      [7:0] resume_char_1,
    output logic      [7:0] resume_char_2,
    output logic      [7:0] pause_char_1,
    output logic      [7:0] pause_char_2,
    input  wire logic       tx_serial,
    input  wire logic       rx_pin,
    output logic            rx_serial
);

    urmd_pkg::urmd_state_s s;
    urmd_pkg::urmd_state_s n;
    urmd_pkg::urmd_bank_e  bank;
    logic                  rd_go;
    logic                  wr_go;
    logic                  div_zero;
    logic [3:0]            chg;
    logic [7:0]            isr_mask;

    always_comb
    begin
        n        = s;
        n.rd_q   = ~cs_n & ~rd_n;
        n.wr_q   = ~cs_n & ~wr_n;
        rd_go    = n.rd_q & ~s.rd_q;
        wr_go    = n.wr_q & ~s.wr_q;
        n.pop    = 1'b0;
        n.txl    = 1'b0;
        n.fcr_wr = 1'b0;
        div_zero = {s.divisor_high, s.dll} == `URMD_ZERO_DIV;
        isr_mask = ~`URMD_ISR_EXT | {8{s.enhanced_function[`URMD_EFR_ENH]}};
        if (s.line_control[`URMD_LCR_DLAB])
        begin
            bank = urmd_pkg::URMD_DIVISOR;
        end
        else
        begin
            bank = urmd_pkg::URMD_NORMAL;
        end
        if (s.line_control == `URMD_LCR_MAGIC)
        begin
            bank = urmd_pkg::URMD_ENHANCED;
        end

        // Change flags: a change seen in the cycle of the clearing read still sets.
        chg     = modem_in ^ s.mprev;
        n.mprev = modem_in;
        if (rd_go && addr == `URMD_OFF_MSTAT && bank != urmd_pkg::URMD_ENHANCED)
        begin
            n.delta = `URMD_RST_NIB;
        end
        n.delta = n.delta | chg;

        // Read side: the answer is captured once per strobe so pops fire once.
        if (rd_go)
        begin
            unique case (addr)
                `URMD_OFF_DATA:
                begin
                    if (s.line_control[`URMD_LCR_DLAB])
                    begin
                        n.rdat = div_zero ? rev_code : s.dll;
                    end
                    else
                    begin
                        n.rdat = rx_char;
                        n.pop  = 1'b1;
                    end
                end
                `URMD_OFF_IEN:
                begin
                    if (s.line_control[`URMD_LCR_DLAB])
                    begin
                        n.rdat = div_zero ? id_code : s.divisor_high;
                    end
                    else
                    begin
                        n.rdat = s.interrupt_enable;
                    end
                end
                `URMD_OFF_ISTAT:
                begin
                    if (bank == urmd_pkg::URMD_ENHANCED)
                    begin
                        n.rdat = s.enhanced_function;
                    end
                    else
                    begin
                        n.rdat = {fifo_on, int_src} & isr_mask;
                    end
                end
                `URMD_OFF_LCTL:
                begin
                    n.rdat = s.line_control;
                end
                `URMD_OFF_MCTL:
                begin
                    n.rdat = (bank == urmd_pkg::URMD_ENHANCED) ? `URMD_RST_BYTE : s.modem_control;
                end
                `URMD_OFF_LSTAT:
                begin
                    n.rdat = (bank == urmd_pkg::URMD_ENHANCED) ? `URMD_RST_BYTE : line_stat;
                end
                `URMD_OFF_MSTAT:
                begin
                    n.rdat = (bank == urmd_pkg::URMD_ENHANCED) ? `URMD_RST_BYTE
                                                               : {modem_in, s.delta};
                end
                `URMD_OFF_SCR:
                begin
                    n.rdat = (bank == urmd_pkg::URMD_ENHANCED) ? `URMD_RST_BYTE : s.scratchpad;
                end
            endcase
        end
        n.oe = n.rd_q;

        // Write side; offsets 5 and 6 outside the enhanced bank fall through.
        if (wr_go)
        begin
            unique case (addr)
                `URMD_OFF_DATA:
                begin
                    if (s.line_control[`URMD_LCR_DLAB])
                    begin
                        n.dll = wdata;
                    end
                    else
                    begin
                        n.txd = wdata;
                        n.txl = 1'b1;
                    end
                end
                `URMD_OFF_IEN:
                begin
                    if (s.line_control[`URMD_LCR_DLAB])
                    begin
                        n.divisor_high = wdata;
                    end
                    else
                    begin
                        n.interrupt_enable = wdata;
                    end
                end
                `URMD_OFF_ISTAT:
                begin
                    if (bank == urmd_pkg::URMD_ENHANCED)
                    begin
                        n.enhanced_function = wdata;
                    end
                    else
                    begin
                        n.fifo_control    = wdata;
                        n.fcr_wr = 1'b1;
                    end
                end
                `URMD_OFF_LCTL:
                begin
                    n.line_control = wdata;
                end
                `URMD_OFF_MCTL:
                begin
                    if (bank == urmd_pkg::URMD_ENHANCED)
                    begin
                        n.xon1 = wdata;
                    end
                    else
                    begin
                        n.modem_control = wdata;
                    end
                end
                `URMD_OFF_LSTAT:
                begin
                    if (bank == urmd_pkg::URMD_ENHANCED)
                    begin
                        n.xon2 = wdata;
                    end
                end
                `URMD_OFF_MSTAT:
                begin
                    if (bank == urmd_pkg::URMD_ENHANCED)
                    begin
                        n.xoff1 = wdata;
                    end
                end
                `URMD_OFF_SCR:
                begin
                    if (bank == urmd_pkg::URMD_ENHANCED)
                    begin
                        n.xoff2 = wdata;
                    end
                    else
                    begin
                        n.scratchpad = wdata;
                    end
                end
            endcase
        end

        // Clearing the extended bits in storage keeps every output honest,
        // so the sleep enable cannot act without the enhanced bit.
        if (!n.enhanced_function[`URMD_EFR_ENH])
        begin
            n.interrupt_enable = n.interrupt_enable & ~`URMD_IER_EXT;
            n.modem_control = n.modem_control & ~`URMD_MCR_EXT;
            n.fifo_control = n.fifo_control & ~`URMD_FCR_EXT;
        end

        n.irq = int_pend & n.modem_control[`URMD_MCR_INTEN];
        n.rxs = n.modem_control[`URMD_MCR_LOOP] ? tx_serial : rx_pin;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign rdata         = s.rdat;
    assign rdata_oe      = s.oe;
    assign rx_pop        = s.pop;
    assign tx_data       = s.txd;
    assign tx_load       = s.txl;
    assign fifo_ctl      = s.fifo_control;
    assign fifo_ctl_wr   = s.fcr_wr;
    assign int_out       = s.irq;
    assign divisor       = {s.divisor_high, s.dll};
    assign line_ctl      = s.line_control;
    assign int_en        = s.interrupt_enable;
    assign enh_fn        = s.enhanced_function;
    assign modem_ctl     = s.modem_control;
    assign resume_char_1 = s.xon1;
    assign resume_char_2 = s.xon2;
    assign pause_char_1  = s.xoff1;
    assign pause_char_2  = s.xoff2;
    assign rx_serial     = s.rxs;

    default clocking dcb @(posedge clk);
    endclocking

    default disable iff (rst);

    a_tx_load_path:
    assert property ((wr_go && addr == `URMD_OFF_DATA && !s.line_control[`URMD_LCR_DLAB])
                     |=> (tx_load && tx_data == $past(wdata)) ##1 !tx_load)
    else $error("transmit write did not pulse the load once");

    a_rx_pop_once:
    assert property ((rd_go && addr == `URMD_OFF_DATA && !s.line_control[`URMD_LCR_DLAB])
                     |=> rx_pop && rdata == $past(rx_char))
    else $error("receive read did not pop or return the byte");

    a_div_high_write:
    assert property ((wr_go && addr == `URMD_OFF_IEN && s.line_control[`URMD_LCR_DLAB])
                     |=> divisor[15:8] == $past(wdata) && int_en == $past(int_en))
    else $error("divisor high write went astray");

    a_rev_code_read:
    assert property ((rd_go && addr == `URMD_OFF_DATA && s.line_control[`URMD_LCR_DLAB] && divisor == 16'h0000)
                     |=> rdata == rev_code)
    else $error("zero divisor did not show the revision code");

    a_line_ctl_write:
    assert property ((wr_go && addr == `URMD_OFF_LCTL) |=> line_ctl == $past(wdata))
    else $error("line control write lost");

    a_irq_gated:
    assert property (int_out |-> modem_ctl[`URMD_MCR_INTEN] && $past(int_pend))
    else $error("interrupt output driven while gated off");

    a_delta_sets:
    assert property ((chg != 4'h0) |=> (s.delta & $past(chg)) == $past(chg))
    else $error("modem change flag lost");

    a_ext_bits_zero:
    assert property (!enh_fn[`URMD_EFR_ENH]
                     |-> (int_en & `URMD_IER_EXT) == 8'h00 && (modem_ctl & `URMD_MCR_EXT) == 8'h00)
    else $error("extended bits set without enhanced enable");

    a_pause_char_write:
    assert property ((wr_go && addr == `URMD_OFF_SCR && line_ctl == `URMD_LCR_MAGIC)
                     |=> pause_char_2 == $past(wdata) && $stable(s.scratchpad))
    else $error("pause character write went astray");

    a_loopback_route:
    assert property (modem_ctl[`URMD_MCR_LOOP] |-> rx_serial == $past(tx_serial))
    else $error("loopback did not route transmit to receive");

    a_ro_write_ignored:
    assert property ((wr_go && (addr == `URMD_OFF_LSTAT || addr == `URMD_OFF_MSTAT)
                      && line_ctl != `URMD_LCR_MAGIC)
                     |=> $stable({s.line_control, s.dll, s.divisor_high, s.interrupt_enable, s.enhanced_function, s.modem_control, s.scratchpad, s.xon2, s.xoff1}))
    else $error("write to read-only offset changed state");

    a_fcr_write_pulse:
    assert property ((wr_go && addr == `URMD_OFF_ISTAT && line_ctl != `URMD_LCR_MAGIC)
                     |=> fifo_ctl_wr && (fifo_ctl & ~`URMD_FCR_EXT) == ($past(wdata) & ~`URMD_FCR_EXT))
    else $error("FIFO control write did not pulse or store");

    a_read_enable_lag:
    assert property (rdata_oe == $past(!cs_n && !rd_n))
    else $error("read enable did not follow the strobe");

    a_id_code_read:
    assert property ((rd_go && addr == `URMD_OFF_IEN && s.line_control[`URMD_LCR_DLAB] && divisor == `URMD_ZERO_DIV)
                     |=> rdata == id_code)
    else $error("zero divisor did not show the identity code");

    a_scratch_write:
    assert property ((wr_go && addr == `URMD_OFF_SCR && line_ctl != `URMD_LCR_MAGIC)
                     |=> s.scratchpad == $past(wdata) && $stable(s.xoff2))
    else $error("scratch write went astray");

    a_resume_char_write:
    assert property ((wr_go && addr == `URMD_OFF_MCTL && line_ctl == `URMD_LCR_MAGIC)
                     |=> resume_char_1 == $past(wdata) && $stable(s.modem_control))
    else $error("resume character write went astray");

endmodule : urmd_top
